// File: rtl/swcfg_consts.svh
// swcfg_consts.svh: offsets, fields, reset values and timing counts
// for the switch strap and configuration loader.
// assumes inclusion by bare name from the swcfg design files.
`ifndef SWCFG_CONSTS_SVH
`define SWCFG_CONSTS_SVH

// register byte offsets on the avalon slave
`define SWCFG_OFS_STATUS 8'h00
`define SWCFG_OFS_PRIO_EN 8'h04
`define SWCFG_OFS_PRIO_MAP 8'h08
`define SWCFG_OFS_RESERVE 8'h0c
`define SWCFG_OFS_EFFECT 8'h10

// reset values
`define SWCFG_PRIO_MAP_RST 8'hf0
`define SWCFG_PRIO_EN_RST 9'h000
`define SWCFG_RSV_BYTES 13'h1800

// status register field positions
`define SWCFG_ST_MODE_LO 0
`define SWCFG_ST_PRIO 2
`define SWCFG_ST_RSV 3
`define SWCFG_ST_SRC 4
`define SWCFG_ST_BUSY 5
`define SWCFG_ST_DONE 6
`define SWCFG_ST_ERR 7
`define SWCFG_ST_READY 8

// effective register field positions
`define SWCFG_EF_RSV 9
`define SWCFG_EF_MODE_LO 10

// eeprom image layout
`define SWCFG_EE_NBYTES 13
`define SWCFG_EE_LAST 4'hc
`define SWCFG_EE_RSV_REG 2
`define SWCFG_EE_RSV_BIT 1
`define SWCFG_EE_MAP_REG 3
`define SWCFG_EE_PORT_REG0 4
`define SWCFG_EE_PORT_BIT 4
`define SWCFG_NPORTS 9

// eeprom serial protocol bytes
`define SWCFG_EE_DEV_WR 8'ha0
`define SWCFG_EE_DEV_RD 8'ha1
`define SWCFG_EE_ADDR0 8'h00

// serial clock timing: quarter of a bit time
`define SWCFG_CLK_NS 40
`define SWCFG_SCL_QTR_NS 2500
`define SWCFG_SCL_QTR_CYC \
   ((`SWCFG_SCL_QTR_NS + `SWCFG_CLK_NS - 1) / `SWCFG_CLK_NS)

`endif

// File: rtl/swcfg_pkg.sv
// swcfg_pkg: types shared by the strap and configuration loader.
// assumes swcfg_consts.svh for all numeric values.
package swcfg_pkg;

   // external mac port operating mode, strap code order
   typedef enum logic [1:0] {
      SWCFG_MODE_OFF,
      SWCFG_MODE_PHY_MII,
      SWCFG_MODE_MAC_MII,
      SWCFG_MODE_SNI
   } swcfg_port_mode_t;

   // strap levels as seen on the pins
   typedef struct packed {
      logic priority_tag_enable;
      logic [1:0] ext_port_mode_select;
      logic priority_buffer_reserve;
      logic config_source_select;
   } swcfg_strap_t;

   // settings handed to the switch core
   typedef struct packed {
      logic [8:0] port_prio_en;
      logic [7:0] prio_high_map;
      logic buf_reserve_en;
      logic [12:0] buf_reserve_bytes;
      swcfg_port_mode_t ext_port_mode;
      logic cpu_programming;
      logic cfg_ready;
   } swcfg_core_cfg_t;

endpackage : swcfg_pkg

// File: rtl/swcfg_ee_reader.sv
// swcfg_ee_reader: serial eeprom sequential reader, two-wire protocol.
// assumes a pull-up on the data line and a single eeprom at the
// standard device address; the clock line is driven push-pull.
`timescale 1ns/1ps
`include "swcfg_consts.svh"

module swcfg_ee_reader
   import swcfg_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // control
   input wire logic start_i,
   output logic busy_o,
   output logic done_o,
   output logic err_o,
   // read data
   output logic byte_vld_o,
   output logic [3:0] byte_idx_o,
   output logic [7:0] byte_o,
   // serial pins
   output logic scl_o,
   input wire logic sda_i,
   output logic sda_oe_o
);

   typedef enum logic [2:0] {
      SWCFG_EE_IDLE, SWCFG_EE_START, SWCFG_EE_TX, SWCFG_EE_RX,
      SWCFG_EE_STOP
   } swcfg_ee_state_t;

   localparam logic [6:0] QTR_CYC = 7'(`SWCFG_SCL_QTR_CYC);

   swcfg_ee_state_t st_q;
   logic [6:0] div_q;
   logic [1:0] qtr_q;
   logic [3:0] bit_q;
   logic [4:0] step_q;
   logic [7:0] sh_q;
   logic fail_q;
   logic tick;
   logic last_rx;
   logic [7:0] tx_byte;
   logic [3:0] rx_idx;

   // quarter-bit enable from the system clock
   assign tick = (st_q != SWCFG_EE_IDLE) && (div_q == QTR_CYC - 7'h01);
   // steps 0..2 send, steps 3..15 receive image bytes
   assign rx_idx = 4'(step_q - 5'h03);
   assign last_rx = (rx_idx == `SWCFG_EE_LAST);
   assign tx_byte = (step_q == 5'h00) ? `SWCFG_EE_DEV_WR :
                    (step_q == 5'h01) ? `SWCFG_EE_ADDR0 : `SWCFG_EE_DEV_RD;
   assign busy_o = (st_q != SWCFG_EE_IDLE);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q <= 7'h00;
      end else begin
         div_q <= (tick || st_q == SWCFG_EE_IDLE) ? 7'h00 : div_q + 7'h01;
      end
   end

   // bit engine: q0 set data, q1 clock high, q2 sample, q3 clock low
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= SWCFG_EE_IDLE;
         qtr_q <= 2'h0;
         bit_q <= 4'h0;
         step_q <= 5'h00;
         sh_q <= 8'h00;
         fail_q <= 1'b0;
         scl_o <= 1'b1;
         sda_oe_o <= 1'b0;
         done_o <= 1'b0;
         err_o <= 1'b0;
         byte_vld_o <= 1'b0;
         byte_idx_o <= 4'h0;
         byte_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         err_o <= 1'b0;
         byte_vld_o <= 1'b0;
         if (tick) begin
            qtr_q <= qtr_q + 2'h1;
         end
         case (st_q)
            SWCFG_EE_IDLE: begin
               qtr_q <= 2'h0;
               if (start_i) begin
                  st_q <= SWCFG_EE_START;
                  step_q <= 5'h00;
                  fail_q <= 1'b0;
               end
            end
            // start: data falls while clock is high
            SWCFG_EE_START: begin
               if (tick) begin
                  case (qtr_q)
                     2'h0: sda_oe_o <= 1'b0;
                     2'h1: scl_o <= 1'b1;
                     2'h2: sda_oe_o <= 1'b1;
                     default: begin
                        scl_o <= 1'b0;
                        bit_q <= 4'h0;
                        sh_q <= tx_byte;
                        st_q <= SWCFG_EE_TX;
                     end
                  endcase
               end
            end
            // shift out msb first, then sample the ack
            SWCFG_EE_TX: begin
               if (tick) begin
                  case (qtr_q)
                     2'h0: sda_oe_o <= (bit_q != 4'h8) && !sh_q[7];
                     2'h1: scl_o <= 1'b1;
                     2'h2: begin
                        if (bit_q == 4'h8 && sda_i) begin
                           fail_q <= 1'b1;
                        end
                     end
                     default: begin
                        scl_o <= 1'b0;
                        sh_q <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h8) begin
                           bit_q <= 4'h0;
                           step_q <= step_q + 5'h01;
                           sh_q <= (step_q == 5'h00) ? `SWCFG_EE_ADDR0
                                                     : `SWCFG_EE_DEV_RD;
                           if (fail_q) begin
                              st_q <= SWCFG_EE_STOP;
                           end else if (step_q == 5'h01) begin
                              st_q <= SWCFG_EE_START;
                           end else if (step_q == 5'h02) begin
                              st_q <= SWCFG_EE_RX;
                           end
                        end
                     end
                  endcase
               end
            end
            // sample data, ack all but the last byte
            SWCFG_EE_RX: begin
               if (tick) begin
                  case (qtr_q)
                     2'h0: sda_oe_o <= (bit_q == 4'h8) && !last_rx;
                     2'h1: scl_o <= 1'b1;
                     2'h2: begin
                        if (bit_q != 4'h8) begin
                           sh_q <= {sh_q[6:0], sda_i};
                        end
                     end
                     default: begin
                        scl_o <= 1'b0;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h8) begin
                           bit_q <= 4'h0;
                           byte_vld_o <= 1'b1;
                           byte_idx_o <= rx_idx;
                           byte_o <= sh_q;
                           step_q <= step_q + 5'h01;
                           if (last_rx) begin
                              st_q <= SWCFG_EE_STOP;
                           end
                        end
                     end
                  endcase
               end
            end
            // stop: data rises while clock is high
            SWCFG_EE_STOP: begin
               if (tick) begin
                  case (qtr_q)
                     2'h0: sda_oe_o <= 1'b1;
                     2'h1: scl_o <= 1'b1;
                     2'h2: sda_oe_o <= 1'b0;
                     default: begin
                        st_q <= SWCFG_EE_IDLE;
                        done_o <= 1'b1;
                        err_o <= fail_q;
                     end
                  endcase
               end
            end
            default: st_q <= SWCFG_EE_IDLE;
         endcase
      end
   end

endmodule : swcfg_ee_reader

// File: rtl/swcfg_top.sv
// swcfg_top: strap capture, eeprom load and effective switch settings.
// assumes straps are static board levels synchronous to clk_sys_i and
// that software reaches the registers over avalon-mm with waitrequest.
`timescale 1ns/1ps
`include "swcfg_consts.svh"

// Behaviour
// - A high priority strap enables tag priority on every port by default.
// - Per-port priority enables loaded from eeprom win over the strap.
// - A default priority map treats tags 4 to 7 as high, 0 to 3 as low.
// - The mode strap picks off, phy-side mii, mac-side mii or seven-wire.
// - A set reserve strap keeps 6 KB of buffer for priority, clear none.
// - The reserve bit from eeprom register 2 bit 1 wins over the strap.
// - The source strap picks processor at 0 and eeprom or none at 1.
// - In eeprom mode the block drives the serial clock and data line.
module swcfg_top
   import swcfg_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // strap pins
   input wire swcfg_strap_t strap_i,
   // serial eeprom pins
   output logic scl_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // avalon-mm slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // settings to the switch core
   output swcfg_core_cfg_t core_cfg_o
);

   // strap capture state
   swcfg_strap_t strap_q;
   logic captured_q;
   // loader state
   logic ld_started_q;
   logic ld_done_q;
   logic ld_err_q;
   logic [7:0] ee_img_q [0:`SWCFG_EE_NBYTES-1];
   // programmed settings and their valid flags
   logic [8:0] port_en_q;
   logic [7:0] map_q;
   logic rsv_q;
   logic pen_vld_q;
   logic rsv_vld_q;
   // bus state
   logic ack_q;
   // reader wires
   logic ee_start;
   logic ee_busy;
   logic ee_done;
   logic ee_err;
   logic ee_vld;
   logic [3:0] ee_idx;
   logic [7:0] ee_byte;
   logic ee_scl;
   logic ee_sda_oe;
   logic ee_ok;
   logic [8:0] ee_port_en;

   // catch straps in the first cycle after reset release
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strap_q <= '0;
         captured_q <= 1'b0;
      end else if (!captured_q) begin
         strap_q <= strap_i;
         captured_q <= 1'b1;
      end
   end

   // source selection and loader start
   logic cpu_mode;
   logic ready;
   // source strap picks processor or eeprom
   assign cpu_mode = !strap_q.config_source_select;
   assign ee_start = captured_q && !cpu_mode && !ld_started_q;
   assign ee_ok = ee_done && !ee_err;
   assign ready = captured_q && (cpu_mode || ld_done_q);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ld_started_q <= 1'b0;
         ld_done_q <= 1'b0;
         ld_err_q <= 1'b0;
      end else begin
         ld_started_q <= ld_started_q || ee_start;
         ld_done_q <= ld_done_q || ee_done;
         ld_err_q <= ld_err_q || (ee_done && ee_err);
      end
   end

   // eeprom image store, one byte per configuration register
   always_ff @(posedge clk_sys_i) begin
      if (ee_vld) begin
         ee_img_q[ee_idx] <= ee_byte;
      end
   end

   // per-port enables sit in bit 4 of registers 4 to 12
   genvar gp;
   generate
      for (gp = 0; gp < `SWCFG_NPORTS; gp++) begin : g_port
         assign ee_port_en[gp] =
            ee_img_q[`SWCFG_EE_PORT_REG0 + gp][`SWCFG_EE_PORT_BIT];
      end
   endgenerate

   swcfg_ee_reader u_ee_reader (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .start_i(ee_start),
      .busy_o(ee_busy),
      .done_o(ee_done),
      .err_o(ee_err),
      .byte_vld_o(ee_vld),
      .byte_idx_o(ee_idx),
      .byte_o(ee_byte),
      .scl_o(ee_scl),
      .sda_i(sda_i),
      .sda_oe_o(ee_sda_oe)
   );

   // clock held high and data released in cpu mode; data line is open drain
   assign scl_o = cpu_mode ? 1'b1 : ee_scl;
   assign sda_o = 1'b0;
   assign sda_oe_o = !cpu_mode && ee_sda_oe;

   // bus decode: one wait state, then answer
   logic req;
   logic wr_acc;
   logic hit_status;
   logic hit_pen;
   logic hit_map;
   logic hit_rsv;
   logic hit_eff;
   logic cpu_wr;
   assign req = avs_read_i || avs_write_i;
   assign avs_waitrequest_o = req && !ack_q;
   assign wr_acc = avs_write_i && ack_q;
   assign hit_status = (avs_address_i == `SWCFG_OFS_STATUS);
   assign hit_pen = (avs_address_i == `SWCFG_OFS_PRIO_EN);
   assign hit_map = (avs_address_i == `SWCFG_OFS_PRIO_MAP);
   assign hit_rsv = (avs_address_i == `SWCFG_OFS_RESERVE);
   assign hit_eff = (avs_address_i == `SWCFG_OFS_EFFECT);
   // settings are writable only by a processor source
   assign cpu_wr = wr_acc && cpu_mode && captured_q;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req && !ack_q;
      end
   end

   // effective settings
   logic [8:0] port_en_eff;
   logic rsv_eff;
   // loaded per-port enables win over the strap
   assign port_en_eff = pen_vld_q ? port_en_q
      : {`SWCFG_NPORTS{strap_q.priority_tag_enable}};
   // loaded reserve bit wins over the strap
   assign rsv_eff = rsv_vld_q ? rsv_q : strap_q.priority_buffer_reserve;

   // programmed settings: bus writes in cpu mode, image in eeprom mode
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port_en_q <= `SWCFG_PRIO_EN_RST;
         map_q <= `SWCFG_PRIO_MAP_RST;
         rsv_q <= 1'b0;
         pen_vld_q <= 1'b0;
         rsv_vld_q <= 1'b0;
      end else if (ee_ok) begin
         port_en_q <= ee_port_en;
         // map as stored, default keeps 4..7 high
         map_q <= ee_img_q[`SWCFG_EE_MAP_REG];
         rsv_q <= ee_img_q[`SWCFG_EE_RSV_REG][`SWCFG_EE_RSV_BIT];
         pen_vld_q <= 1'b1;
         rsv_vld_q <= 1'b1;
      end else if (cpu_wr) begin
         if (hit_pen && avs_byteenable_i[0]) begin
            port_en_q[7:0] <= avs_writedata_i[7:0];
            pen_vld_q <= 1'b1;
         end
         if (hit_pen && avs_byteenable_i[1]) begin
            port_en_q[8] <= avs_writedata_i[8];
            pen_vld_q <= 1'b1;
         end
         if (hit_map && avs_byteenable_i[0]) begin
            map_q <= avs_writedata_i[7:0];
         end
         if (hit_rsv && avs_byteenable_i[0]) begin
            rsv_q <= avs_writedata_i[0];
            rsv_vld_q <= 1'b1;
         end
      end
   end

   // read mux; unmapped offsets read zero
   logic [31:0] st_word;
   logic [31:0] eff_word;
   logic [31:0] rd_mux;
   assign st_word = {23'h000000, ready, ld_err_q, ld_done_q, ee_busy,
                     strap_q.config_source_select,
                     strap_q.priority_buffer_reserve,
                     strap_q.priority_tag_enable,
                     strap_q.ext_port_mode_select};
   assign eff_word = {20'h00000, strap_q.ext_port_mode_select, rsv_eff,
                      port_en_eff};
   assign rd_mux = hit_status ? st_word :
                   hit_pen ? {23'h000000, port_en_q} :
                   hit_map ? {24'h000000, map_q} :
                   hit_rsv ? {31'h00000000, rsv_q} :
                   hit_eff ? eff_word : 32'h00000000;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (avs_read_i && !ack_q) begin
         avs_readdata_o <= rd_mux;
      end
   end

   // settings to the core, registered
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_cfg_o <= '0;
      end else begin
         core_cfg_o.port_prio_en <= port_en_eff;
         // map bit n set means tag n is high priority
         core_cfg_o.prio_high_map <= map_q;
         core_cfg_o.buf_reserve_en <= rsv_eff;
         core_cfg_o.buf_reserve_bytes <= rsv_eff ? `SWCFG_RSV_BYTES
                                                 : 13'h0000;
         // mode strap code maps straight onto the mode
         core_cfg_o.ext_port_mode <=
            swcfg_port_mode_t'(strap_q.ext_port_mode_select);
         core_cfg_o.cpu_programming <= cpu_mode;
         core_cfg_o.cfg_ready <= ready;
      end
   end

endmodule : swcfg_top

// File: verif/swcfg_ee_model.sv
// swcfg_ee_model: behavioural serial eeprom for sequential reads.
// assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module swcfg_ee_model (
   // serial pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic pull_o,
   // image, byte 0 in the low bits, and ack refusal
   input wire logic [103:0] img_i,
   input wire logic nack_i
);
   int cnt = 20; // 20 means idle, outside any frame
   logic wr = 1'b1;
   logic rdm = 1'b0;
   logic [7:0] sh = 8'h00;
   logic [3:0] ptr = 4'h0;
   initial pull_o = 1'b0;

   always @(negedge sda_i) if (scl_i) begin
      cnt = -1;
      wr = 1'b1;
      rdm = 1'b0;
   end
   always @(posedge sda_i) if (scl_i) cnt = 20;

   // ack and data only change while the clock is low
   always @(negedge scl_i) begin
      if (cnt < 9) cnt = (cnt == 8) ? 0 : cnt + 1;
      pull_o = 1'b0;
      if (cnt < 8 && !wr) pull_o = !img_i[8 * ptr + 7 - cnt];
      if (cnt == 8 && wr) pull_o = !nack_i; // refusal leaves it released
   end

   // bits, device byte and the master's ack
   always @(posedge scl_i) begin
      if (cnt < 8 && wr) sh = {sh[6:0], sda_i};
      if (cnt == 8 && wr && sh[7:1] == 7'h50) rdm = sh[0];
      else if (cnt == 8 && wr) ptr = sh[3:0];
      if (cnt == 8 && !wr) ptr = ptr + 4'h1;
      if (cnt == 8 && !wr && sda_i) cnt = 20; // nack: let go for stop
      if (cnt == 8 && rdm) wr = 1'b0;
   end
endmodule : swcfg_ee_model

// File: verif/swcfg_top_sva.sv
// swcfg_top_sva: port checks for the strap and config loader.
// assumes one clock domain; bound to swcfg_top at the foot.
`timescale 1ns/1ps
`include "swcfg_consts.svh"
module swcfg_top_sva
   import swcfg_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // watched ports
   input wire swcfg_strap_t strap_i,
   input wire logic scl_o,
   input wire logic sda_oe_o,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire swcfg_core_cfg_t core_cfg_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   logic [1:0] since_q;

   // edges since reset release; settings show at the second
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) since_q <= 2'h0;
      else if (since_q != 2'h3) since_q <= since_q + 2'h1;
   end

   // request steps: one wait state, then a taken write
   sequence s_one_wait;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   sequence s_en_write;
      avs_write_i && !avs_waitrequest_o && core_cfg_o.cpu_programming
         && avs_address_i == `SWCFG_OFS_PRIO_EN
         && avs_byteenable_i[1:0] == 2'h3;
   endsequence

   a_bus_one_wait: assert property (
      $rose(avs_read_i || avs_write_i) |-> s_one_wait)
      else $error("waitrequest not one cycle");
   a_bus_idle: assert property (
      !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("waitrequest without request");
   a_mode_strap: assert property (
      since_q == 2'h2 |-> core_cfg_o.ext_port_mode
         == $past(strap_i.ext_port_mode_select, 2))
      else $error("port mode differs from strap");
   a_src_strap: assert property (
      since_q == 2'h2 |-> core_cfg_o.cpu_programming
         == !$past(strap_i.config_source_select, 2))
      else $error("source differs from strap");
   a_straps_held: assert property (
      since_q == 2'h3 |-> $stable(core_cfg_o.ext_port_mode)
         && $stable(core_cfg_o.cpu_programming))
      else $error("strap settings moved");
   a_cpu_pins_idle: assert property (
      core_cfg_o.cpu_programming |-> scl_o && !sda_oe_o)
      else $error("serial pins active in processor mode");
   a_prio_strap: assert property (
      since_q == 2'h2 |-> core_cfg_o.port_prio_en
         == {9{$past(strap_i.priority_tag_enable, 2)}}
         && core_cfg_o.prio_high_map == `SWCFG_PRIO_MAP_RST)
      else $error("priority enables differ from strap");
   a_rsv_strap: assert property (
      since_q == 2'h2 |-> core_cfg_o.buf_reserve_en
         == $past(strap_i.priority_buffer_reserve, 2))
      else $error("reserve differs from strap");
   a_rsv_bytes: assert property (
      core_cfg_o.buf_reserve_bytes == (core_cfg_o.buf_reserve_en
         ? `SWCFG_RSV_BYTES : 13'h0))
      else $error("reserve size wrong");
   a_en_write: assert property (
      s_en_write |-> ##2 core_cfg_o.port_prio_en
         == $past(avs_writedata_i[8:0], 2))
      else $error("port enables not taken from write");
   a_scl_slow: assert property (
      $changed(scl_o) |=> $stable(scl_o)[*8])
      else $error("serial clock too fast");
endmodule : swcfg_top_sva

bind swcfg_top swcfg_top_sva swcfg_top_sva_i (.clk_sys_i, .rst_n_i,
   .strap_i, .scl_o, .sda_oe_o, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
   .avs_waitrequest_o, .core_cfg_o);

// File: verif/tb_swcfg_top.sv
// tb_swcfg_top: strap capture, processor writes and eeprom loads.
// assumes swcfg_ee_model on the serial pins and a pulled-up data line.
`timescale 1ns/1ps
`include "swcfg_consts.svh"
module tb_swcfg_top;
   import swcfg_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   swcfg_strap_t strap_i = 5'h00;
   logic scl_o;
   logic sda_o;
   logic sda_oe_o;
   logic ee_pull;
   logic ee_nack = 1'b0;
   logic [103:0] ee_img = '0;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   swcfg_core_cfg_t core_cfg_o;
   logic [31:0] rd_last;
   logic [31:0] seed = 32'h2c;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int n_mismatch = 0;
   int checks = 0;
   // open-drain data line with a pull-up
   wire sda_i = !(sda_oe_o || ee_pull);

   swcfg_top swcfg_top_i (.clk_sys_i, .rst_n_i, .strap_i, .scl_o, .sda_i,
      .sda_o, .sda_oe_o, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
      .avs_waitrequest_o, .core_cfg_o);
   swcfg_ee_model swcfg_ee_model_i (.scl_i(scl_o), .sda_i,
      .pull_o(ee_pull), .img_i(ee_img), .nack_i(ee_nack));

   initial forever #20 clk_sys_i = ~clk_sys_i;

   // xorshift source for straps, write data and the image
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one avalon transfer; waits as long as waitrequest says
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      rd_last = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask : rd

   // read results are matched against the oldest note
   always @(posedge clk_sys_i)
      if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
         chk("readdata", exp_q.pop_front(), avs_readdata_o & msk_q.pop_front());

   task automatic do_reset(input swcfg_strap_t s);
      rst_n_i <= 1'b0;
      strap_i <= s;
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
   endtask : do_reset

   task automatic cfg_chk(input logic [8:0] pe, input logic [7:0] mp,
      input logic rv, input logic [1:0] md, input logic cpu);
      chk("port_prio_en", pe, core_cfg_o.port_prio_en);
      chk("prio_high_map", mp, core_cfg_o.prio_high_map);
      chk("buf_reserve_en", rv, core_cfg_o.buf_reserve_en);
      chk("buf_reserve_bytes", rv ? 13'h1800 : 13'h0,
         core_cfg_o.buf_reserve_bytes);
      chk("ext_port_mode", md, core_cfg_o.ext_port_mode);
      chk("cpu_programming", cpu, core_cfg_o.cpu_programming);
      chk("sda_o", 1'b0, sda_o);
   endtask : cfg_chk

   task automatic strap_chk(input swcfg_strap_t s);
      cfg_chk({9{s.priority_tag_enable}}, 8'hf0, s.priority_buffer_reserve,
         s.ext_port_mode_select, !s.config_source_select);
   endtask : strap_chk

   task automatic wait_load(output logic [31:0] st);
      for (int n = 0; n < 1000; n++) begin
         repeat (100) @(posedge clk_sys_i);
         bus(1'b0, `SWCFG_OFS_STATUS, 32'h0);
         if (rd_last[7:6] !== 2'b00) break;
      end
      st = rd_last;
   endtask : wait_load

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   // a load takes about 40000 cycles; allow twice the run
   initial begin
      #(80000 * 40);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      swcfg_strap_t s;
      logic [31:0] r, t, st;
      // processor mode: every port mode, then strap pins moved
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         s = r[4:0];
         s.ext_port_mode_select = i[1:0];
         s.config_source_select = 1'b0;
         do_reset(s);
         strap_chk(s);
         rd(`SWCFG_OFS_STATUS, {27'h0, s[0], s[1], s[4], s[3:2]},
            32'h1f);
         strap_i <= ~s;
         repeat (3) @(posedge clk_sys_i);
         strap_chk(s);
      end
      $display("test strap capture done");
      // processor writes override straps; read-only and unmapped
      r = rnd();
      bus(1'b1, `SWCFG_OFS_PRIO_EN, r);
      bus(1'b1, `SWCFG_OFS_PRIO_MAP, r);
      bus(1'b1, `SWCFG_OFS_RESERVE, {31'h0, !s[1]});
      bus(1'b1, `SWCFG_OFS_STATUS, 32'hffffffff);
      cfg_chk(r[8:0], r[7:0], !s[1], s[3:2], 1'b1);
      rd(`SWCFG_OFS_EFFECT, {20'h0, s[3:2], !s[1], r[8:0]}, 32'hfff);
      rd(`SWCFG_OFS_STATUS, {27'h0, s[0], s[1], s[4], s[3:2]},
         32'h1f);
      rd(8'h44, 32'h0, 32'hffffffff);
      $display("test processor writes done");
      // eeprom load: reserve, map and port enables win
      r = rnd();
      for (int k = 0; k < 13; k++) begin
         t = rnd();
         ee_img[8 * k +: 8] = t[7:0];
      end
      ee_img[17] = 1'b1;
      for (int k = 0; k < 9; k++) ee_img[8 * (4 + k) + 4] = r[k];
      s = {1'b1, r[10:9], 1'b0, 1'b1};
      do_reset(s);
      wait_load(st);
      chk("load status", 32'h40, st & 32'hc0);
      cfg_chk(r[8:0], ee_img[31:24], 1'b1, r[10:9], 1'b0);
      chk("cfg_ready", 32'h1, core_cfg_o.cfg_ready);
      bus(1'b1, `SWCFG_OFS_PRIO_EN, ~r);
      repeat (2) @(posedge clk_sys_i);
      chk("port_prio_en", r[8:0], core_cfg_o.port_prio_en);
      $display("test eeprom load done");
      // eeprom refuses its address: straps stay in force
      ee_nack = 1'b1;
      s = {1'b1, r[12:11], 1'b1, 1'b1};
      do_reset(s);
      wait_load(st);
      chk("load status", 32'hc0, st & 32'hc0);
      strap_chk(s);
      $display("test eeprom refusal done");
      tally_and_finish();
   end
endmodule : tb_swcfg_top
